// File: hdl/smc_config_timing.sv
// smc_config_timing: smbus configuration register, bus monitor and master
// scl timing. assumes timer overflow ticks are one-cycle pulses on i_clk and
// that the byte engine requests scl cycles and reports mastership.
`timescale 1ns/10ps
`default_nettype none
module smc_config_timing
   import smc_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_sfr_wr,
   input  wire logic       i_sfr_rd,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic [7:0] i_sfr_wdata,
   output logic      [7:0] o_sfr_rdata,
   input  wire logic       i_t0_ovf,
   input  wire logic       i_t1_ovf,
   input  wire logic       i_t2h_ovf,
   input  wire logic       i_t2l_ovf,
   input  wire logic       i_t3_split,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_scl_out,
   output logic            o_scl_oe,
   input  wire logic       i_master,
   input  wire logic       i_scl_run,
   input  wire logic       i_addr_match,
   input  wire logic       i_slave_irq,
   input  wire logic       i_master_irq,
   output logic            o_addr_ack,
   output logic            o_irq,
   output logic            o_start,
   output logic            o_stop,
   output logic            o_scl_rise,
   output logic            o_scl_fall,
   output logic            o_busy,
   output logic            o_enable,
   output logic            o_hold_extend,
   output logic      [2:0] o_sda_hold_ticks,
   output logic            o_t3_reload_hi,
   output logic            o_t3_reload_lo
);
   logic [7:0] cfg_reg;
   logic       busy_reg;
   logic       inh_active_reg;
   logic       scl_s, sda_s, scl_d_reg, sda_d_reg;
   logic       tick;
   logic [3:0] free_cnt_reg;
   logic [1:0] ph_cnt_reg;
   logic       free_to;
   logic       start_ev, stop_ev;
   logic       en;

   smc_sync u_scl (.i_clk(i_clk), .i_resetn(i_resetn), .i_pin(i_scl),
                   .o_level(scl_s));
   smc_sync u_sda (.i_clk(i_clk), .i_resetn(i_resetn), .i_pin(i_sda),
                   .o_level(sda_s));

   assign en = cfg_reg[SMC_BIT_ENABLE];

   // configuration register; busy bit reads hardware state
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         cfg_reg <= SMC_CFG_RESET;
      else if (i_sfr_wr && i_sfr_addr == SMC_CFG_ADDR)
         cfg_reg <= i_sfr_wdata & SMC_WR_MASK;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_sfr_rdata <= 8'h00;
      else if (i_sfr_rd && i_sfr_addr == SMC_CFG_ADDR)
      begin
         o_sfr_rdata               <= cfg_reg;
         o_sfr_rdata[SMC_BIT_BUSY] <= busy_reg;
      end
      else
         o_sfr_rdata <= 8'h00;
   end

   // tick selection, gated by role unless the free timeout is enabled
   always_comb
   begin
      unique case (smc_src_t'(cfg_reg[SMC_CS_HI:SMC_CS_LO]))
         SMC_SRC_T0:  tick = i_t0_ovf;
         SMC_SRC_T1:  tick = i_t1_ovf;
         SMC_SRC_T2H: tick = i_t2h_ovf;
         SMC_SRC_T2L: tick = i_t2l_ovf;
      endcase
      if (!(i_master || cfg_reg[SMC_BIT_FREETO]))
         tick = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign start_ev = en && scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_ev  = en && scl_s && scl_d_reg && !sda_d_reg && sda_s;

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_start    <= 1'b0;
         o_stop     <= 1'b0;
         o_scl_rise <= 1'b0;
         o_scl_fall <= 1'b0;
      end
      else
      begin
         o_start    <= start_ev;
         o_stop     <= stop_ev;
         o_scl_rise <= en && scl_s && !scl_d_reg;
         o_scl_fall <= en && !scl_s && scl_d_reg;
      end
   end

   // free timeout: more than ten periods of both lines high
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || !en || !scl_s || !sda_s)
         free_cnt_reg <= 4'h0;
      else if (tick && free_cnt_reg <= 4'(SMC_FREE_PERIODS))
         free_cnt_reg <= free_cnt_reg + 4'h1;
   end
   assign free_to = cfg_reg[SMC_BIT_FREETO] && tick
                  && free_cnt_reg == 4'(SMC_FREE_PERIODS);

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || !en)
         busy_reg <= 1'b0;
      else if (start_ev)
         busy_reg <= 1'b1;
      else if (stop_ev || free_to)
         busy_reg <= 1'b0;
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_busy <= 1'b0;
      else
         o_busy <= busy_reg;
   end

   // inhibit latched at start so an ongoing transfer is not cut short
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         inh_active_reg <= 1'b0;
      else if (start_ev)
         inh_active_reg <= cfg_reg[SMC_BIT_INHIBIT];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_addr_ack <= 1'b0;
         o_irq      <= 1'b0;
      end
      else
      begin
         o_addr_ack <= en && i_addr_match && !inh_active_reg;
         // master interrupts bypass the inhibit entirely
         o_irq <= en && (i_master_irq
                  || (i_slave_irq && !inh_active_reg));
      end
   end

   // master scl: low one tick, high two ticks; the low phase counts at once,
   // the high phase only once the line really sits high
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || !en || !i_master || !i_scl_run)
      begin
         o_scl_out  <= 1'b1;
         // oe moves with the drive level, never a cycle behind it
         o_scl_oe   <= 1'b0;
         ph_cnt_reg <= 2'h0;
      end
      else if (!o_scl_out)
      begin
         if (tick)
            ph_cnt_reg <= ph_cnt_reg + 2'h1;
         if (tick && ph_cnt_reg + 2'h1 >= 2'(SMC_LOW_TICKS))
         begin
            o_scl_out  <= 1'b1;
            o_scl_oe   <= 1'b0;
            ph_cnt_reg <= 2'h0;
         end
      end
      else if (!scl_s)
         ph_cnt_reg <= 2'h0;
      else if (tick)
      begin
         if (ph_cnt_reg + 2'h1 >= 2'(SMC_HIGH_TICKS))
         begin
            o_scl_out  <= 1'b0;
            o_scl_oe   <= 1'b1;
            ph_cnt_reg <= 2'h0;
         end
         else
            ph_cnt_reg <= ph_cnt_reg + 2'h1;
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_enable         <= 1'b0;
         o_hold_extend    <= 1'b0;
         o_sda_hold_ticks <= 3'(SMC_HOLD_NORMAL);
         o_t3_reload_hi   <= 1'b0;
         o_t3_reload_lo   <= 1'b0;
      end
      else
      begin
         o_enable      <= en;
         o_hold_extend <= cfg_reg[SMC_BIT_HOLDEXT];
         o_sda_hold_ticks <= cfg_reg[SMC_BIT_HOLDEXT]
                           ? 3'(SMC_HOLD_EXT) : 3'(SMC_HOLD_NORMAL);
         o_t3_reload_hi <= cfg_reg[SMC_BIT_SCLTO] && scl_s;
         o_t3_reload_lo <= cfg_reg[SMC_BIT_SCLTO] && scl_s
                           && !i_t3_split;
      end
   end
endmodule : smc_config_timing
`default_nettype wire

// File: pkg/smc_pkg.sv
// smc_pkg: constants for the smbus clock/configuration block.
// assumes an 8-bit special-register port at the documented address.
package smc_pkg;
   localparam logic [7:0] SMC_CFG_ADDR     = 8'hc1;
   localparam logic [7:0] SMC_CFG_RESET    = 8'h00;
   localparam int         SMC_BIT_ENABLE   = 7;
   localparam int         SMC_BIT_INHIBIT  = 6;
   localparam int         SMC_BIT_BUSY     = 5;
   localparam int         SMC_BIT_HOLDEXT  = 4;
   localparam int         SMC_BIT_SCLTO    = 3;
   localparam int         SMC_BIT_FREETO   = 2;
   localparam int         SMC_CS_HI        = 1;
   localparam int         SMC_CS_LO        = 0;
   localparam logic [7:0] SMC_WR_MASK      = 8'hdf;
   localparam int         SMC_FREE_PERIODS = 10;
   localparam int         SMC_LOW_TICKS    = 1;
   localparam int         SMC_HIGH_TICKS   = 2;
   localparam int         SMC_HOLD_NORMAL  = 1;
   localparam int         SMC_HOLD_EXT     = 4;
   typedef enum logic [1:0] {
      SMC_SRC_T0, SMC_SRC_T1, SMC_SRC_T2H, SMC_SRC_T2L
   } smc_src_t;
endpackage : smc_pkg

// File: hdl/smc_sync.sv
// smc_sync: three-flop synchroniser for a pin, change taken when stages 2/3 agree.
// assumes the pin is asynchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module smc_sync
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_pin,
   output logic      o_level
);
   logic [2:0] stage_reg;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         stage_reg <= 3'h7;
      else
         stage_reg <= {stage_reg[1:0], i_pin};
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_level <= 1'b1;
      else if (stage_reg[1] == stage_reg[2])
         o_level <= stage_reg[2];
   end
endmodule : smc_sync
`default_nettype wire

// File: verif/smc_config_timing_asserts.sv
// smc_config_timing_asserts: port checks for smc_config_timing.
// assumes it is bound to the block and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module smc_config_timing_asserts
   import smc_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_resetn,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic       i_master,
   input wire logic       o_scl_out,
   input wire logic       o_scl_oe,
   input wire logic       o_start,
   input wire logic       o_stop,
   input wire logic       o_busy,
   input wire logic       o_enable,
   input wire logic       o_hold_extend,
   input wire logic [2:0] o_sda_hold_ticks,
   input wire logic       o_t3_reload_hi,
   input wire logic       o_t3_reload_lo
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_cfg_wr;
      i_sfr_wr && i_sfr_addr == SMC_CFG_ADDR;
   endsequence
   sequence s_busy_gone;
      ##[0:3] !o_busy;
   endsequence
   enable_write_a: assert property (
      (s_cfg_wr ##0 i_sfr_wdata[SMC_BIT_ENABLE]) |-> ##2 o_enable)
      else $error("enable bit not taken");
   hold_select_a: assert property (
      o_sda_hold_ticks == (o_hold_extend ? SMC_HOLD_EXT : SMC_HOLD_NORMAL))
      else $error("hold count wrong");
   drive_low_a: assert property (o_scl_oe |-> !o_scl_out)
      else $error("scl driven high");
   reload_pair_a: assert property (o_t3_reload_lo |-> o_t3_reload_hi)
      else $error("low byte reload alone");
   start_stop_a: assert property (!(o_start && o_stop))
      else $error("start and stop together");
   stop_clear_a: assert property (o_stop |-> s_busy_gone)
      else $error("busy kept after stop");
   start_busy_a: assert property (
      o_start && o_enable |-> ##[0:3] o_busy)
      else $error("busy not set by start");
   master_only_a: assert property ($rose(o_scl_oe) |-> $past(i_master))
      else $error("scl pulled while not master");
endmodule : smc_config_timing_asserts
bind smc_config_timing smc_config_timing_asserts u_chk (.i_clk, .i_resetn,
   .i_sfr_wr, .i_sfr_addr, .i_sfr_wdata, .i_master, .o_scl_out, .o_scl_oe,
   .o_start, .o_stop, .o_busy, .o_enable, .o_hold_extend, .o_sda_hold_ticks,
   .o_t3_reload_hi, .o_t3_reload_lo);
`default_nettype wire

// File: verif/smc_bus_model.sv
// smc_bus_model: far-side bus master on scl/sda with pull-ups.
// assumes the bench calls go() and wires both lines to the block.
`timescale 1ns/10ps
`default_nettype none
module smc_bus_model
(
   input  wire logic i_scl_oe,
   output logic      o_scl,
   output logic      o_sda
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   // open drain: a released line floats to its pull-up
   assign o_scl = !(scl_low || i_scl_oe);
   assign o_sda = !sda_low;
   // 0 start, 1 stop, 2 release both without a stop
   task automatic go(input int m);
      if (m == 0)
      begin
         #80 sda_low = 1'b1;
         #80 scl_low = 1'b1;
      end
      else
      begin
         sda_low = (m == 1);
         #80 scl_low = 1'b0;
         #80 sda_low = 1'b0;
      end
      #80;
   endtask : go
endmodule : smc_bus_model
`default_nettype wire

// File: verif/smc_config_timing_tb_top.sv
// smc_config_timing_tb_top: self-checking bench for smc_config_timing.
// assumes smc_bus_model on the pins; timer ticks are made here.
`timescale 1ns/10ps
`default_nettype none
module smc_config_timing_tb_top;
   import smc_pkg::*;
   typedef struct packed {logic [7:0] wd, rb; logic [2:0] ht;} smc_row_t;
   smc_row_t rows [4] = '{'{8'h80, 8'h80, 3'h1}, '{8'hdd, 8'hdd, 3'h4},
                          '{8'hbe, 8'h9e, 3'h4}, '{8'h83, 8'h83, 3'h1}};
   logic       clk, rstn, sw, sr, split, mst, run, am, sirq, mirq, p;
   logic       scl, sda, scl_oe, scl_out, aack, irq, busy, rlh, rll;
   logic       srise, sfall;
   logic [7:0] addr, wd, rdat;
   logic [3:0] tk;
   logic [2:0] hold;
   logic [1:0] tsrc;
   int         n_fail, compares, cnt, c, k, lo, nr, nf;
   smc_config_timing DUT (.i_clk(clk), .i_resetn(rstn), .i_sfr_wr(sw),
      .i_sfr_rd(sr), .i_sfr_addr(addr), .i_sfr_wdata(wd), .o_sfr_rdata(rdat),
      .i_t0_ovf(tk[0]), .i_t1_ovf(tk[1]), .i_t2h_ovf(tk[2]),
      .i_t2l_ovf(tk[3]), .i_t3_split(split), .i_scl(scl), .i_sda(sda),
      .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_master(mst),
      .i_scl_run(run), .i_addr_match(am), .i_slave_irq(sirq),
      .i_master_irq(mirq), .o_addr_ack(aack), .o_irq(irq), .o_start(),
      .o_stop(), .o_scl_rise(srise), .o_scl_fall(sfall), .o_busy(busy),
      .o_enable(),
      .o_hold_extend(), .o_sda_hold_ticks(hold), .o_t3_reload_hi(rlh),
      .o_t3_reload_lo(rll));
   smc_bus_model bm (.i_scl_oe(scl_oe), .o_scl(scl), .o_sda(sda));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cnt <= (cnt == 9) ? 0 : cnt + 1;
      tk  <= (cnt == 9) ? 4'h1 << tsrc : 4'h0;
   end
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      sw   <= 1'b1;
      @(posedge clk);
      sw <= 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      addr <= a;
      sr   <= 1'b1;
      @(posedge clk);
      sr <= 1'b0;
      @(negedge clk);
      chk("rdata", e, rdat);
   endtask : rd
   task automatic wt(ref logic s, input logic v, input int n, string nm);
      for (c = 0; c < n && s !== v; c++)
         @(negedge clk);
      chk(nm, v, s);
   endtask : wt
   task automatic fr(int m);
      bm.go(m);
      @(negedge clk);
   endtask : fr
   task automatic stop_test;
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   initial
   begin
      #60000;
      n_fail++;
      stop_test();
   end
   initial
   begin
      {sw, sr, split, mst, run, am, sirq, mirq, tsrc, addr, wd} = '0;
      rstn = 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(SMC_CFG_ADDR, SMC_CFG_RESET);
      chk("rst", 8'h81, {scl_out, 4'h0, hold});
      rd(8'hc0, 8'h00);
      mst <= 1'b1;
      run <= 1'b1;
      for (k = 0; k < 4; k++)
      begin
         wr(SMC_CFG_ADDR, rows[k].wd);
         tsrc <= rows[k].wd[1:0];
         rd(SMC_CFG_ADDR, rows[k].rb);
         chk("hold", rows[k].ht, hold);
         wt(scl_oe, 0, 80, "oe");
         wt(scl_oe, 1, 80, "oe");
      end
      {lo, k, p, nr, nf} = '0;
      repeat (300)
      begin
         @(negedge clk);
         lo += scl_oe;
         k  += scl_oe & !p;
         p  = scl_oe;
         nr += srise;
         nf += sfall;
      end
      chk("bits", 1, k >= 9 && k <= 11);
      chk("low", 1, lo >= 10 * k - 10 && lo <= 11 * k + 10);
      chk("rises", 1, nr >= k - 1 && nr <= k + 1);
      chk("falls", 1, nf >= k - 1 && nf <= k + 1);
      run <= 1'b0;
      wt(scl_oe, 0, 60, "oe");
      mst <= 1'b0;
      wr(SMC_CFG_ADDR, 8'h80);
      am <= 1'b1;
      fr(0);
      wt(busy, 1, 40, "busy");
      chk("ack", 1, aack);
      wr(SMC_CFG_ADDR, 8'hc0);
      sirq <= 1'b1;
      wt(irq, 1, 4, "irq");
      chk("ack", 1, aack);
      sirq <= 1'b0;
      fr(1);
      wt(busy, 0, 40, "busy");
      fr(0);
      sirq <= 1'b1;
      repeat (4) @(negedge clk);
      chk("ack", 0, aack);
      chk("irq", 0, irq);
      {sirq, mirq, mst} <= 3'h3;
      wt(irq, 1, 4, "irq");
      {mirq, mst} <= 2'h0;
      wr(SMC_CFG_ADDR, 8'h85);
      tsrc <= 2'h1;
      fr(2);
      // at most nine ticks seen here, so the bus is not yet free
      repeat (70) @(negedge clk);
      chk("busy", 1, busy);
      wt(busy, 0, 60, "busy");
      wr(SMC_CFG_ADDR, 8'h88);
      wt(rll, 1, 8, "rlo");
      split <= 1'b1;
      wt(rll, 0, 8, "rlo");
      chk("rhi", 1, rlh);
      fr(0);
      wt(rlh, 0, 8, "rhi");
      // timer3 handler after a stuck-low scl: drop and restore the enable
      wr(SMC_CFG_ADDR, 8'h08);
      wt(busy, 0, 8, "busy");
      wr(SMC_CFG_ADDR, 8'h88);
      fr(1);
      stop_test();
   end
endmodule : smc_config_timing_tb_top
`default_nettype wire
